// [common/dsl_map.vh]
// Constants for the multiply-accumulate slice: register map, fields, codes.
`ifndef DSL_MAP_VH
`define DSL_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DSL_ADR_CFG     8'h00
`define DSL_ADR_PAT_LO  8'h04
`define DSL_ADR_PAT_HI  8'h08
`define DSL_ADR_MSK_LO  8'h0c
`define DSL_ADR_MSK_HI  8'h10
`define DSL_ADR_RES_LO  8'h14
`define DSL_ADR_RES_HI  8'h18

// ----------------------------------------
// Configuration fields and reset values
// ----------------------------------------
`define DSL_CFG_SIMD     1:0
`define DSL_CFG_XORW     3:2
`define DSL_CFG_PRE      4
`define DSL_CFG_W        5
`define DSL_CFG_RST      5'h00
`define DSL_PAT_RST      48'h0
`define DSL_MSK_RST      48'h0
`define DSL_RES_FLAG_LSB 16

// ----------------------------------------
// SIMD modes and XOR widths
// ----------------------------------------
`define DSL_SIMD_ONE48  2'h0
`define DSL_SIMD_TWO24  2'h1
`define DSL_SIMD_FOUR12 2'h2
`define DSL_LANE_W      12
`define DSL_LANES       4
`define DSL_TWO24_CUT   2
`define DSL_XGRPS       8
`define DSL_XOR_12      2'h0
`define DSL_XOR_24      2'h1
`define DSL_XOR_48      2'h2
`define DSL_XOR_96      2'h3

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define DSL_OP_ADD    4'h0
`define DSL_OP_SUB    4'h1
`define DSL_OP_AND    4'h2
`define DSL_OP_OR     4'h3
`define DSL_OP_XOR    4'h4
`define DSL_OP_NAND   4'h5
`define DSL_OP_NOR    4'h6
`define DSL_OP_XNOR   4'h7
`define DSL_OP_ANDN   4'h8
`define DSL_OP_ORN    4'h9
`define DSL_OP_NOTX   4'ha
`define DSL_OP_PASSX  4'hb
`define DSL_OP_CNTUP  4'hc
`define DSL_OP_CNTDN  4'hd

`endif

// [rtl/dsl_slice.v]
// Multiply-accumulate slice with SIMD adder, logic unit, XOR reducer and pattern detector.
// Function
// - Signed 27 by 18 multiply giving the full signed product.
// - 48-bit accumulator adds the new result to its previous value when enabled.
// - Run-time bypass feeds two 48-bit operands to the arithmetic unit instead.
// - SIMD adder splits into two 24-bit or four 12-bit lanes without crossing carries.
// - Logic unit computes one of ten bitwise functions chosen by operation select.
// - Pre-adder sums two inputs ahead of the multiplier for symmetric filters.
// - XOR reduction over 96 bits in 12, 24, 48 or 96 bit groups.
// - 48-bit pattern detector compares the result against a masked pattern.
// - Pattern detector with logic unit output evaluates a 96-bit-wide logic function.
// - Accumulator counts up or down by a supplied step each enabled cycle.
`include "dsl_map.vh"
`default_nettype none

module dsl_slice (
  input  wire        clk,
  input  wire        srst,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Fabric operand side
  input  wire        ce,
  input  wire [3:0]  op_sel,
  input  wire        use_mult,
  input  wire        acc_sel,
  input  wire [26:0] pre_a,
  input  wire [26:0] pre_d,
  input  wire [17:0] mul_b,
  input  wire [47:0] opnd_ab,
  input  wire [47:0] opnd_c,
  output reg  [47:0] result_ff,
  output reg         result_vld_ff,
  output reg         pat_det_ff,
  output reg         pat_bdet_ff,
  output reg  [7:0]  xor_out_ff
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg  [`DSL_CFG_W-1:0] cfg_ff;
  reg  [47:0]           pat_ff;
  reg  [47:0]           msk_ff;
  wire                  wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge that completes the cycle, where the master samples ack high.
  wire                  wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  reg  [31:0]           nxt_rdat;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] neu;
    input [3:0]  sel;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = sel[k] ? neu[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------
  // Byte-lane write merge
  // ----------------------------------------
  // Upper words are narrower than the bus; their spare lanes are merged and then dropped.
  wire [31:0]           cfg_wrd = merge({27'h0, cfg_ff}, wb_dat_i, wb_sel_i);
  wire [31:0]           pat_wrd = merge({16'h0, pat_ff[47:32]}, wb_dat_i, wb_sel_i);
  wire [31:0]           msk_wrd = merge({16'h0, msk_ff[47:32]}, wb_dat_i, wb_sel_i);

  always @(posedge clk) begin
    if (srst) begin
      cfg_ff   <= `DSL_CFG_RST;
      pat_ff   <= `DSL_PAT_RST;
      msk_ff   <= `DSL_MSK_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      // Ack one cycle after the request and drop it the next, so one request is one access.
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? nxt_rdat : 32'h0;
      if (wb_wr) begin
        case (wb_adr_i)
          `DSL_ADR_CFG: begin
            cfg_ff <= cfg_wrd[`DSL_CFG_W-1:0];
          end
          `DSL_ADR_PAT_LO: begin
            pat_ff[31:0] <= merge(pat_ff[31:0], wb_dat_i, wb_sel_i);
          end
          `DSL_ADR_PAT_HI: begin
            pat_ff[47:32] <= pat_wrd[15:0];
          end
          `DSL_ADR_MSK_LO: begin
            msk_ff[31:0] <= merge(msk_ff[31:0], wb_dat_i, wb_sel_i);
          end
          `DSL_ADR_MSK_HI: begin
            msk_ff[47:32] <= msk_wrd[15:0];
          end
          default: begin
            cfg_ff <= cfg_ff;
          end
        endcase
      end
    end
  end

  // Unmapped and read-only addresses still ack; unmapped reads return zero.
  always @* begin
    case (wb_adr_i)
      `DSL_ADR_CFG:    nxt_rdat = {27'h0, cfg_ff};
      `DSL_ADR_PAT_LO: nxt_rdat = pat_ff[31:0];
      `DSL_ADR_PAT_HI: nxt_rdat = {16'h0, pat_ff[47:32]};
      `DSL_ADR_MSK_LO: nxt_rdat = msk_ff[31:0];
      `DSL_ADR_MSK_HI: nxt_rdat = {16'h0, msk_ff[47:32]};
      `DSL_ADR_RES_LO: nxt_rdat = result_ff[31:0];
      `DSL_ADR_RES_HI: nxt_rdat = {14'h0, pat_bdet_ff, pat_det_ff, result_ff[47:32]};
      default:         nxt_rdat = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  // SIMD code three is not a mode of its own; the adder then runs as one 48-bit lane.
  wire [1:0]            simd_mode = cfg_ff[`DSL_CFG_SIMD];
  wire [1:0]            xor_width = cfg_ff[`DSL_CFG_XORW];
  wire                  pre_on    = cfg_ff[`DSL_CFG_PRE];

  // ----------------------------------------
  // Input pipeline stage
  // ----------------------------------------
  reg  [26:0] a_ff;
  reg  [26:0] d_ff;
  reg  [17:0] b_ff;
  reg  [47:0] ab_ff;
  reg  [47:0] c_ff;
  reg  [3:0]  op_ff;
  reg         mult_ff;
  reg         accs_ff;
  reg         vld_ff;

  always @(posedge clk) begin
    if (srst) begin
      a_ff    <= 27'h0;
      d_ff    <= 27'h0;
      b_ff    <= 18'h0;
      ab_ff   <= 48'h0;
      c_ff    <= 48'h0;
      op_ff   <= `DSL_OP_ADD;
      mult_ff <= 1'b0;
      accs_ff <= 1'b0;
      vld_ff  <= 1'b0;
    end else begin
      vld_ff <= ce;
      // Operands and select are captured together, relying on the fabric to align them.
      if (ce) begin
        a_ff    <= pre_a;
        d_ff    <= pre_d;
        b_ff    <= mul_b;
        ab_ff   <= opnd_ab;
        c_ff    <= opnd_c;
        op_ff   <= op_sel;
        mult_ff <= use_mult;
        accs_ff <= acc_sel;
      end
    end
  end

  // ----------------------------------------
  // Pre-adder and multiplier
  // ----------------------------------------
  // The pre-adder wraps at 27 bits; callers keep the sum in range.
  wire signed [26:0] pre_sum = pre_on ? $signed(a_ff + d_ff)
                                      : $signed(a_ff);
  wire signed [44:0] prod    = pre_sum * $signed(b_ff);
  wire        [47:0] prod_x  = {{3{prod[44]}}, prod};

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  wire        is_cnt = (op_ff == `DSL_OP_CNTUP) | (op_ff == `DSL_OP_CNTDN);
  wire        is_sub = (op_ff == `DSL_OP_SUB) | (op_ff == `DSL_OP_CNTDN);
  wire [47:0] x_opnd = is_cnt ? c_ff : (mult_ff ? prod_x : ab_ff);
  wire [47:0] y_opnd = (is_cnt | accs_ff) ? result_ff : c_ff;

  // ----------------------------------------
  // SIMD adder
  // ----------------------------------------
  wire [47:0]         sum;
  wire [47:0]         xb = is_sub ? ~x_opnd : x_opnd;
  wire [`DSL_LANES:0] lane_cy;
  genvar              li;

  // Subtract is y plus inverted x with carry-in one at every lane start.
  // The top lane's carry out falls off the end, as in any 48-bit add.
  assign lane_cy[0] = is_sub;

  generate
    for (li = 0; li < `DSL_LANES; li = li + 1) begin : g_lane
      wire        cut;
      wire        cin;
      wire [12:0] lane;
      assign cut  = ((li == `DSL_TWO24_CUT) && (simd_mode == `DSL_SIMD_TWO24)) ||
                    ((li != 0) && (simd_mode == `DSL_SIMD_FOUR12));
      assign cin  = cut ? is_sub : lane_cy[li];
      assign lane = {1'b0, y_opnd[li*`DSL_LANE_W +: `DSL_LANE_W]} +
                    {1'b0, xb[li*`DSL_LANE_W +: `DSL_LANE_W]} + {12'h0, cin};
      assign sum[li*`DSL_LANE_W +: `DSL_LANE_W] = lane[`DSL_LANE_W-1:0];
      assign lane_cy[li+1] = lane[`DSL_LANE_W];
    end
  endgenerate

  // ----------------------------------------
  // Logic unit and result select
  // ----------------------------------------
  // Codes past the ten logic functions fall through to the adder, so spare codes add.
  reg [47:0] alu_z;

  always @* begin
    case (op_ff)
      `DSL_OP_AND:   alu_z = x_opnd & y_opnd;
      `DSL_OP_OR:    alu_z = x_opnd | y_opnd;
      `DSL_OP_XOR:   alu_z = x_opnd ^ y_opnd;
      `DSL_OP_NAND:  alu_z = ~(x_opnd & y_opnd);
      `DSL_OP_NOR:   alu_z = ~(x_opnd | y_opnd);
      `DSL_OP_XNOR:  alu_z = ~(x_opnd ^ y_opnd);
      `DSL_OP_ANDN:  alu_z = x_opnd & ~y_opnd;
      `DSL_OP_ORN:   alu_z = x_opnd | ~y_opnd;
      `DSL_OP_NOTX:  alu_z = ~x_opnd;
      `DSL_OP_PASSX: alu_z = x_opnd;
      default:       alu_z = sum;
    endcase
  end

  // ----------------------------------------
  // Pattern detector
  // ----------------------------------------
  // Masked bits are ignored; the complement match lets rounding logic see both edges.
  // Checking a logic result for all ones or zeros extends that function to a second word.
  wire [47:0] pd_diff = (alu_z ^ pat_ff) & ~msk_ff;
  wire [47:0] pd_bdif = (alu_z ^ ~pat_ff) & ~msk_ff;

  // ----------------------------------------
  // XOR reducer
  // ----------------------------------------
  wire [95:0] xin = {ab_ff, c_ff};
  wire [7:0]  grp;
  reg  [7:0]  xo;
  genvar      gi;

  // Each group is a plain parity tree; wider widths fold group parities, not raw bits.
  generate
    for (gi = 0; gi < `DSL_XGRPS; gi = gi + 1) begin : g_grp
      assign grp[gi] = ^xin[gi*`DSL_LANE_W +: `DSL_LANE_W];
    end
  endgenerate

  always @* begin
    case (xor_width)
      `DSL_XOR_12: xo = grp;
      `DSL_XOR_24: xo = {4'h0,
                         grp[7] ^ grp[6],
                         grp[5] ^ grp[4],
                         grp[3] ^ grp[2],
                         grp[1] ^ grp[0]};
      `DSL_XOR_48: xo = {6'h0, ^grp[7:4], ^grp[3:0]};
      `DSL_XOR_96: xo = {7'h0, ^grp};
      default:     xo = 8'h0;
    endcase
  end

  // ----------------------------------------
  // Result stage
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      result_ff     <= 48'h0;
      result_vld_ff <= 1'b0;
      pat_det_ff    <= 1'b0;
      pat_bdet_ff   <= 1'b0;
      xor_out_ff    <= 8'h0;
    end else begin
      // Result, flags and XOR outputs only move on a captured operation, so a stalled fabric sees a steady result.
      result_vld_ff <= vld_ff;
      if (vld_ff) begin
        result_ff   <= alu_z;
        pat_det_ff  <= ~|pd_diff;
        pat_bdet_ff <= ~|pd_bdif;
        xor_out_ff  <= xo;
      end
    end
  end

endmodule // dsl_slice

`default_nettype wire

// [test/dsl_fabric_model.sv]
// Fabric-side model that presents operands and operation selects to the slice.
`default_nettype none
module dsl_fabric_model (
  input  wire logic        clk,
  output var  logic        ce,
  output var  logic [3:0]  op_sel,
  output var  logic        use_mult,
  output var  logic        acc_sel,
  output var  logic [26:0] pre_a,
  output var  logic [26:0] pre_d,
  output var  logic [17:0] mul_b,
  output var  logic [47:0] opnd_ab,
  output var  logic [47:0] opnd_c
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Drive tasks
  // ----
  initial begin
    {ce, op_sel, use_mult, acc_sel, pre_a, pre_d, mul_b, opnd_ab, opnd_c} = '0;
  end
  // Multiplier inputs ride on the wide operands to keep one call per operation.
  task automatic issue(input logic [3:0] op, input logic um, input logic as,
                       input logic [47:0] ab, input logic [47:0] c);
    @(posedge clk);
    ce       <= 1'b1;
    op_sel   <= op;
    use_mult <= um;
    acc_sel  <= as;
    opnd_ab  <= ab;
    opnd_c   <= c;
    pre_a    <= ab[26:0];
    pre_d    <= c[26:0];
    mul_b    <= c[47:30];
  endtask
  // Real fabric leaves junk on the operands once ce drops.
  task automatic idle();
    @(posedge clk);
    ce      <= 1'b0;
    op_sel  <= ~op_sel;
    opnd_ab <= ~opnd_ab;
    opnd_c  <= ~opnd_c;
  endtask
endmodule // dsl_fabric_model
`default_nettype wire

// [test/dsl_slice_monitor.sv]
// Checker for the slice's bus handshake and datapath timing.
`include "dsl_map.vh"
`default_nettype none
module dsl_slice_monitor (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ce,
  input wire logic [3:0]  op_sel,
  input wire logic        use_mult,
  input wire logic        acc_sel,
  input wire logic [47:0] opnd_ab,
  input wire logic [47:0] opnd_c,
  input wire logic [47:0] result_ff,
  input wire logic        result_vld_ff,
  input wire logic        pat_det_ff,
  input wire logic [7:0]  xor_out_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_vld_late: assert property (ce |-> ##2 result_vld_ff)
    else $error("no valid two cycles after capture");
  a_vld_cause: assert property (result_vld_ff |-> $past(ce, 2))
    else $error("valid without capture");
  // Without a capture the result and XOR outputs must hold, even while fabric operands wander.
  a_res_hold: assert property (!$past(ce, 2) |-> $stable(result_ff) && $stable(xor_out_ff))
    else $error("result moved without capture");
  a_rst_zero: assert property ($fell(srst) |-> result_ff == 48'h0 && !pat_det_ff)
    else $error("outputs not cleared by reset");
  a_and_logic: assert property (ce && op_sel == `DSL_OP_AND && !use_mult && !acc_sel |->
    ##2 result_ff == ($past(opnd_ab, 2) & $past(opnd_c, 2)))
    else $error("and result wrong");
endmodule // dsl_slice_monitor
`default_nettype wire

// [test/tb_dsl_slice.sv]
// Self-checking testbench for the multiply-accumulate slice.
`include "dsl_map.vh"
`default_nettype none
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_dsl_slice;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Bench
  // ----
  localparam logic [47:0] lx = 48'h0f0f_3c3c_ff00;
  localparam logic [47:0] ly = 48'h00ff_5a5a_0ff0;
  logic        clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ce, use_mult, acc_sel;
  logic        result_vld_ff, pat_det_ff, pat_bdet_ff;
  logic [7:0]  wb_adr_i, xor_out_ff;
  logic [3:0]  wb_sel_i, op_sel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [26:0] pre_a, pre_d;
  logic [17:0] mul_b;
  logic [47:0] opnd_ab, opnd_c, result_ff;
  int          n_fail = 0;
  int          compares = 0;
  dsl_slice u_dut (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ce, .op_sel, .use_mult, .acc_sel, .pre_a, .pre_d,
    .mul_b, .opnd_ab, .opnd_c, .result_ff, .result_vld_ff, .pat_det_ff, .pat_bdet_ff,
    .xor_out_ff);
  dsl_fabric_model u_fab (.clk, .ce, .op_sel, .use_mult, .acc_sel, .pre_a, .pre_d,
    .mul_b, .opnd_ab, .opnd_c);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, wd};
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n == 20) n_fail++;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, adr, d, x);
  endtask
  task automatic done();
    u_fab.idle();
    @(posedge clk);
    #1;
  endtask
  task automatic run(input logic [3:0] op, input logic um, input logic [47:0] ab, c, e);
    u_fab.issue(op, um, 1'b0, ab, c);
    done();
    `CHK("result", e, result_ff)
  endtask
  task automatic t_regs();
    logic [31:0] r;
    wb(1'b0, `DSL_ADR_CFG, 32'h0, r);
    `CHK("cfg", 32'h0, r)
    wr(8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    wr(`DSL_ADR_MSK_HI, 32'hffff_1234);
    wb(1'b0, `DSL_ADR_MSK_HI, 32'h0, r);
    `CHK("msk_hi", 32'h0000_1234, r)
    wr(`DSL_ADR_MSK_HI, 32'h0);
  endtask
  task automatic t_mult();
    run(`DSL_OP_PASSX, 1'b1, 48'h07ff_fffd, 48'h0001_4000_0000, 48'hffff_ffff_fff1);
    run(`DSL_OP_PASSX, 1'b0, 48'h07ff_fffd, 48'h0001_4000_0000, 48'h07ff_fffd);
    wr(`DSL_ADR_CFG, 32'h10);
    run(`DSL_OP_PASSX, 1'b1, 48'h64, 48'hfffe_47ff_ffec, 48'hffff_ffff_fdd0);
    wr(`DSL_ADR_CFG, 32'h0);
  endtask
  task automatic t_acc();
    u_fab.issue(`DSL_OP_ADD, 1'b0, 1'b0, 48'h10, 48'h5);
    u_fab.issue(`DSL_OP_ADD, 1'b0, 1'b1, 48'h20, 48'h0);
    u_fab.issue(`DSL_OP_SUB, 1'b0, 1'b1, 48'h36, 48'h0);
    done();
    `CHK("acc", 48'hffff_ffff_ffff, result_ff)
    `CHK("vld", 1'b1, result_vld_ff)
  endtask
  task automatic t_simd();
    wr(`DSL_ADR_CFG, 32'h1);
    run(`DSL_OP_ADD, 1'b0, 48'h0000_01ff_ffff, 48'h0000_0100_0001, 48'h0000_0200_0000);
    wr(`DSL_ADR_CFG, 32'h2);
    run(`DSL_OP_ADD, 1'b0, 48'h000f_ff00_0fff, 48'h0010_0100_1001, 48'h0010_0000_1000);
    run(`DSL_OP_SUB, 1'b0, 48'h000f_ff00_0fff, 48'h0010_0100_1001, 48'h0010_0200_1002);
    wr(`DSL_ADR_CFG, 32'h0);
  endtask
  task automatic t_logic();
    logic [47:0] e [2:11];
    e = '{lx & ly, lx | ly, lx ^ ly, ~(lx & ly), ~(lx | ly), ~(lx ^ ly), lx & ~ly,
          lx | ~ly, ~lx, lx};
    for (int i = 2; i < 12; i++) run(4'(i), 1'b0, lx, ly, e[i]);
  endtask
  task automatic t_xor();
    logic [7:0] xe [4];
    xe = '{8'h18, 8'h06, 8'h03, 8'h00};
    for (int w = 0; w < 4; w++) begin
      wr(`DSL_ADR_CFG, 32'(w << 2));
      run(`DSL_OP_ADD, 1'b0, 48'h1, 48'h0010_0000_0003, 48'h0010_0000_0004);
      `CHK("xor", xe[w], xor_out_ff)
    end
  endtask
  task automatic t_pat();
    logic [31:0] r;
    wr(`DSL_ADR_PAT_LO, 32'h1234_5678);
    wr(`DSL_ADR_PAT_HI, 32'h9abc);
    run(`DSL_OP_OR, 1'b0, 48'h9abc_0000_0000, 48'h1234_5678, 48'h9abc_1234_5678);
    `CHK("det", 2'h2, {pat_det_ff, pat_bdet_ff})
    wb(1'b0, `DSL_ADR_RES_HI, 32'h0, r);
    `CHK("res_hi", 32'h0001_9abc, r)
    wr(`DSL_ADR_MSK_LO, 32'hf);
    run(`DSL_OP_ADD, 1'b0, 48'h9abc_1234_5670, 48'h3, 48'h9abc_1234_5673);
    `CHK("masked", 1'b1, pat_det_ff)
    run(`DSL_OP_NOTX, 1'b0, 48'h9abc_1234_5678, 48'h0, 48'h6543_edcb_a987);
    `CHK("bdet", 2'h1, {pat_det_ff, pat_bdet_ff})
  endtask
  task automatic t_cnt();
    u_fab.issue(`DSL_OP_PASSX, 1'b0, 1'b0, 48'h2, 48'h0);
    repeat (3) u_fab.issue(`DSL_OP_CNTUP, 1'b0, 1'b0, 48'h0, 48'h3);
    u_fab.issue(`DSL_OP_CNTDN, 1'b0, 1'b0, 48'h0, 48'h5);
    done();
    `CHK("count", 48'h6, result_ff)
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK("reset", 48'h0, result_ff)
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h0, 4'hf, 32'h0};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_mult();
    t_acc();
    t_simd();
    t_logic();
    t_xor();
    t_pat();
    t_cnt();
    complete_run();
  end
  initial begin
    #100us;
    n_fail++;
    complete_run();
  end
endmodule // tb_dsl_slice
bind dsl_slice dsl_slice_monitor u_mon (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .ce, .op_sel, .use_mult, .acc_sel, .opnd_ab, .opnd_c, .result_ff,
  .result_vld_ff, .pat_det_ff, .xor_out_ff);
`default_nettype wire
